// [design/bsc_pkg.sv]
// Package holding constants and types for the boot and security control block.
package bsc_pkg;

  localparam int unsigned BSC_ADDR_W = 32;
  localparam int unsigned BSC_UID_W = 128;
  localparam int unsigned BSC_OPT_W = 8;
  localparam logic [11:0] BSC_SEC_OFFSET = 12'h040e;
  localparam logic [7:0] BSC_SEC_UNSECURE = 8'h02;
  localparam logic [1:0] BSC_SEC_FIELD_UNSECURE = 2'h2;
  localparam logic [BSC_ADDR_W-1:0] BSC_ROM_BASE = 32'h1c00_0000;
  localparam logic [BSC_ADDR_W-1:0] BSC_FLASH_BASE = 32'h0000_0000;
  localparam logic [BSC_OPT_W-1:0] BSC_OPT_RESET = 8'hff;
  localparam logic BSC_ROM_RESET = 1'b1;
  localparam logic BSC_SECURED_RESET = 1'b1;
  localparam logic [7:0] BSC_SEC_RESET = 8'hff;
  localparam logic [BSC_ADDR_W-1:0] BSC_VECTOR_OFFSET_REGISTER_RESET = 32'h0000_0000;
  localparam logic [BSC_ADDR_W-1:0] BSC_VECTOR_OFFSET_REGISTER_MASK = 32'hffff_ff80;
  localparam logic [BSC_UID_W-1:0] BSC_UID_RESET = 128'h0;

  typedef enum logic [2:0] {
    BSC_LOAD,
    BSC_RUN,
    BSC_ERASE,
    BSC_ERASE_WAIT
  } bsc_state_t;

endpackage : bsc_pkg

// [design/bsc_top.sv]
// Boot source selection, security gating and unique ID load.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Boot source is internal flash or on-chip ROM.
// - Boot option bits are read-only, copied from the option byte at the load after reset.
// - Blank part boots ROM with vectors at ROM base; otherwise vectors at flash.
// - A programmable vector offset register relocates the table after reset.
// - Security setting at offset 0x40e decides whether the part is secured.
// - While secured, debug-port memory accesses are refused.
// - While secured, bootloader flash readout commands are rejected.
// - Debugger mass-erase request runs an erase-all-blocks operation.
// - Bootloader erase-all-unsecure command or matching backdoor key unsecures.
// - After power-on reset the 128-bit unique ID is loaded.
module bsc_top
  import bsc_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  por,
  input  wire logic                  nvm_valid,
  input  wire logic                  nvm_blank,
  input  wire logic [BSC_OPT_W-1:0]  flash_boot_option_word,
  input  wire logic [7:0]            nvm_sec_byte,
  input  wire logic [BSC_UID_W-1:0]  nvm_uid,
  input  wire logic                  vector_offset_register_we,
  input  wire logic [BSC_ADDR_W-1:0] vector_offset_register_wdata,
  input  wire logic                  dbg_mem_req,
  input  wire logic                  mailbox_mass_erase,
  input  wire logic                  bl_read_req,
  input  wire logic                  bl_erase_unsecure,
  input  wire logic                  bl_key_req,
  input  wire logic                  bl_key_match,
  input  wire logic                  erase_done,
  output logic                       ready,
  output logic                       boot_from_rom,
  output logic [BSC_OPT_W-1:0]       boot_option_register,
  output logic [BSC_ADDR_W-1:0]      vector_offset_register,
  output logic                       secured,
  output logic                       dbg_mem_grant,
  output logic                       dbg_mem_refuse,
  output logic                       bl_read_grant,
  output logic                       bl_read_refuse,
  output logic                       erase_all_start,
  output logic                       erase_busy,
  output logic [BSC_UID_W-1:0]       system_config_block_uid
);

  bsc_state_t                  state_q, state_d;
  logic                        rom_q, rom_d;
  logic [BSC_OPT_W-1:0]        opt_q, opt_d;
  logic [BSC_ADDR_W-1:0]       vector_offset_register_q, vector_offset_register_d;
  logic                        sec_q, sec_d;
  logic                        start_q, start_d;
  logic [BSC_UID_W-1:0]        uid_q, uid_d;
  logic                        uid_pend_q, uid_pend_d;
  logic                        load_take;
  logic                        in_run;
  logic                        erase_req;
  logic                        key_ok;
  logic                        erase_end;
  logic                        sec_from_nvm;

  // Request decode shared by the groups below.
  assign load_take    = (state_q == BSC_LOAD) && nvm_valid;
  assign in_run       = (state_q == BSC_RUN);
  // Both erase sources start the same erase-all-blocks operation.
  assign erase_req    = in_run && (mailbox_mass_erase || bl_erase_unsecure);
  // An erase asked for in the same cycle wins over a key.
  assign key_ok       = in_run && bl_key_req && bl_key_match && !erase_req;
  // A done seen while still starting belongs to no request of ours and is ignored.
  assign erase_end    = (state_q == BSC_ERASE_WAIT) && erase_done;
  // Only the unsecure value in bits 1:0 clears security; every other value there leaves the part secured.
  assign sec_from_nvm = (nvm_sec_byte[1:0] != BSC_SEC_FIELD_UNSECURE);

  // Load once after reset, then run; an erase keeps the part out of run until done.
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      BSC_LOAD:
      begin
        if (load_take)
        begin
          state_d = BSC_RUN;
        end
      end
      BSC_RUN:
      begin
        if (erase_req)
        begin
          state_d = BSC_ERASE;
        end
      end
      BSC_ERASE:
      begin
        state_d = BSC_ERASE_WAIT;
      end
      BSC_ERASE_WAIT:
      begin
        if (erase_end)
        begin
          state_d = BSC_RUN;
        end
      end
      default:
      begin
        state_d = BSC_LOAD;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= BSC_LOAD;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Boot choice and option bits change only at a load, so software sees them read-only.
  always_comb
  begin
    rom_d = rom_q;
    opt_d = opt_q;
    if (load_take)
    begin
      rom_d = nvm_blank;
      opt_d = flash_boot_option_word;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      rom_q <= BSC_ROM_RESET;
      opt_q <= BSC_OPT_RESET;
    end
    else
    begin
      rom_q <= rom_d;
      opt_q <= opt_d;
    end
  end

  always_comb
  begin
    vector_offset_register_d = vector_offset_register_q;
    if (load_take)
    begin
      vector_offset_register_d = nvm_blank ? BSC_ROM_BASE : BSC_FLASH_BASE;
    end
    else if (in_run && vector_offset_register_we)
    begin
      // The low bits are forced to zero since the table must sit on an aligned base.
      vector_offset_register_d = vector_offset_register_wdata & BSC_VECTOR_OFFSET_REGISTER_MASK;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      vector_offset_register_q <= BSC_VECTOR_OFFSET_REGISTER_RESET;
    end
    else
    begin
      vector_offset_register_q <= vector_offset_register_d;
    end
  end

  // Security is cleared by a finished erase, an accepted key, or a load that reads the unsecure code.
  always_comb
  begin
    sec_d = sec_q;
    if (load_take)
    begin
      sec_d = sec_from_nvm;
    end
    else if (key_ok || erase_end)
    begin
      sec_d = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      sec_q <= BSC_SECURED_RESET;
    end
    else
    begin
      sec_q <= sec_d;
    end
  end

  // A one-cycle start, so that the erase engine never sees a level it could restart on.
  always_comb
  begin
    start_d = erase_req;
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      start_q <= 1'b0;
    end
    else
    begin
      start_q <= start_d;
    end
  end

  // Only a power-on reset arms a reload; other resets keep the copy last taken.
  always_comb
  begin
    uid_d      = uid_q;
    uid_pend_d = uid_pend_q | por;
    if (load_take && uid_pend_q)
    begin
      uid_d      = nvm_uid;
      uid_pend_d = por;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      uid_q      <= uid_q;
      uid_pend_q <= uid_pend_q | por;
    end
    else
    begin
      uid_q      <= uid_d;
      uid_pend_q <= uid_pend_d;
    end
  end

  // Nothing is granted before the load finishes or while an erase is running.
  assign ready                   = (state_q == BSC_RUN);
  assign boot_from_rom           = rom_q;
  assign boot_option_register    = opt_q;
  assign vector_offset_register  = vector_offset_register_q;
  assign secured                 = sec_q;
  assign erase_all_start         = start_q;
  assign system_config_block_uid = uid_q;

  // Busy covers both erase states, the whole span of an erase in which ready is low.
  always_comb
  begin
    case (state_q)
      BSC_ERASE,
      BSC_ERASE_WAIT:
      begin
        erase_busy = 1'b1;
      end
      default:
      begin
        erase_busy = 1'b0;
      end
    endcase
  end

  // Grants answer in the same cycle; a refusal is any request that is not granted.
  always_comb
  begin
    dbg_mem_grant  = 1'b0;
    dbg_mem_refuse = 1'b0;
    bl_read_grant  = 1'b0;
    bl_read_refuse = 1'b0;
    if (dbg_mem_req)
    begin
      if (ready && !sec_q)
      begin
        dbg_mem_grant = 1'b1;
      end
      else
      begin
        dbg_mem_refuse = 1'b1;
      end
    end
    if (bl_read_req)
    begin
      if (ready && !sec_q)
      begin
        bl_read_grant = 1'b1;
      end
      else
      begin
        bl_read_refuse = 1'b1;
      end
    end
  end

endmodule : bsc_top

`default_nettype wire

// [tb/bsc_erase_engine.sv]
// Flash erase engine model: answers a start with a done pulse after a delay.
`timescale 1ns/1ps
`default_nettype none
module bsc_erase_engine (
  input  wire logic       mclk,
  input  wire logic       erase_all_start,
  input  wire logic [3:0] erase_dly,
  output logic            erase_done
);
  initial erase_done = 1'b0;
  always @(posedge erase_all_start)
  begin
    repeat (erase_dly) @(posedge mclk);
    @(negedge mclk);
    erase_done = 1'b1;
    @(negedge mclk);
    erase_done = 1'b0;
  end
endmodule : bsc_erase_engine
`default_nettype wire

// [tb/bsc_sva.sv]
// Assertions on the ports of the boot and security block.
`timescale 1ns/1ps
`default_nettype none
module bsc_sva (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       nvm_valid,
  input wire logic       dbg_mem_req,
  input wire logic       bl_read_req,
  input wire logic       bl_key_req,
  input wire logic       bl_key_match,
  input wire logic       mailbox_mass_erase,
  input wire logic       bl_erase_unsecure,
  input wire logic       erase_done,
  input wire logic       ready,
  input wire logic       secured,
  input wire logic       dbg_mem_grant,
  input wire logic       dbg_mem_refuse,
  input wire logic       bl_read_grant,
  input wire logic       erase_all_start,
  input wire logic       erase_busy,
  input wire logic [7:0] flash_boot_option_word,
  input wire logic [7:0] nvm_sec_byte,
  input wire logic [7:0] boot_option_register
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire ld = !ready && nvm_valid && !erase_busy;
  sequence s_pl; erase_all_start ##1 !erase_all_start; endsequence
  property p_dg; dbg_mem_req && secured |-> !dbg_mem_grant && dbg_mem_refuse; endproperty
  a_dg: assert property (p_dg) else $error("dbg");
  property p_bl; bl_read_req && secured |-> !bl_read_grant; endproperty
  a_bl: assert property (p_bl) else $error("read");
  property p_st; ready && (mailbox_mass_erase || bl_erase_unsecure) |=> s_pl; endproperty
  a_st: assert property (p_st) else $error("start");
  property p_op; ld |=> boot_option_register == $past(flash_boot_option_word); endproperty
  a_op: assert property (p_op) else $error("option");
  property p_sc; ld |=> secured == (($past(nvm_sec_byte) & 8'h03) != 8'h02); endproperty
  a_sc: assert property (p_sc) else $error("secure");
  property p_en; erase_busy && erase_done && !erase_all_start |=> ready && !secured; endproperty
  a_en: assert property (p_en) else $error("end");
  property p_ky; ready && bl_key_req && bl_key_match && !mailbox_mass_erase
    && !bl_erase_unsecure |=> !secured; endproperty
  a_ky: assert property (p_ky) else $error("key");
  property p_ds; dbg_mem_req && !ready |-> dbg_mem_refuse; endproperty
  a_ds: assert property (p_ds) else $error("busy");
endmodule : bsc_sva
bind bsc_top bsc_sva u_sva (.*);
`default_nettype wire

// [tb/test_boot_and_security_control.sv]
// Self-checking bench for the boot and security block.
`timescale 1ns/1ps
`default_nettype none
module test_boot_and_security_control;
  import bsc_pkg::*;
  logic mclk = 0, rst = 1, por = 1, nvm_valid = 0, nvm_blank = 0, vector_offset_register_we = 0, bl_read_req = 0;
  logic dbg_mem_req = 0, mailbox_mass_erase = 0, bl_erase_unsecure = 0, bl_key_req = 0;
  logic bl_key_match = 1, erase_done, ready, boot_from_rom, secured, dbg_mem_grant;
  logic dbg_mem_refuse, bl_read_grant, bl_read_refuse, erase_all_start, erase_busy;
  logic [7:0] flash_boot_option_word = 0, nvm_sec_byte = 0, boot_option_register, lf = 8'h5e;
  logic [31:0] vector_offset_register_wdata = 0, vector_offset_register;
  logic [127:0] nvm_uid = 0, system_config_block_uid, uid_exp = 0;
  logic [3:0] erase_dly = 1;
  logic sec_exp = 1;
  int err_total = 0, n_compared = 0, cyc = 0;
  bsc_top DUT (.*);
  bsc_erase_engine u_eng (.*);
  function automatic logic [7:0] nxt(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  function automatic logic exp_secured(logic [7:0] b);
    return b[1:0] != BSC_SEC_FIELD_UNSECURE;
  endfunction : exp_secured
  task automatic chk(logic [127:0] s, logic [127:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, s, e);
    end
  endtask : chk
  task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      print_verdict();
    end
  end
  initial
  begin
    for (int i = 0; i < 9; i++)
    begin
      lf = nxt(lf);
      rst = 1;
      por = i != 4 && i != 7;
      nvm_valid = 0;
      nvm_blank = i[0];
      flash_boot_option_word = lf;
      nvm_sec_byte = i == 0 || i == 5 ? 8'hff : i == 1 ? 8'h02 : nxt(lf);
      nvm_uid = {16{lf}};
      erase_dly = lf[3:0] | 4'h1;
      bl_key_match = i != 5;
      if (por)
        uid_exp = nvm_uid;
      repeat (8) @(negedge mclk);
      rst = 0;
      por = 0;
      nvm_valid = 1;
      @(negedge mclk);
      sec_exp = exp_secured(nvm_sec_byte);
      chk(ready, 1);
      chk(boot_from_rom, i[0]);
      chk(boot_option_register, lf);
      chk(vector_offset_register, i[0] ? BSC_ROM_BASE : BSC_FLASH_BASE);
      chk(secured, sec_exp);
      chk(system_config_block_uid, uid_exp);
      dbg_mem_req = 1;
      bl_read_req = 1;
      vector_offset_register_we = 1;
      vector_offset_register_wdata = {4{lf}};
      @(negedge mclk);
      chk(dbg_mem_refuse, sec_exp);
      chk(bl_read_grant, !sec_exp);
      chk(bl_read_refuse, sec_exp);
      chk(vector_offset_register, {4{lf}} & BSC_VECTOR_OFFSET_REGISTER_MASK);
      vector_offset_register_we = 0;
      mailbox_mass_erase = i % 3 == 0;
      bl_erase_unsecure = i % 3 == 1;
      bl_key_req = i % 3 == 2;
      @(negedge mclk);
      mailbox_mass_erase = 0;
      bl_erase_unsecure = 0;
      bl_key_req = 0;
      chk(erase_all_start, i % 3 != 2);
      chk(dbg_mem_refuse, i % 3 != 2 || i == 5 && sec_exp);
      for (int k = 0; k < 40 && erase_busy; k++)
        @(negedge mclk);
      chk(erase_busy, 0);
      chk(secured, i == 5 && sec_exp);
      chk(dbg_mem_grant, !(i == 5 && sec_exp));
      dbg_mem_req = 0;
      bl_read_req = 0;
    end
    print_verdict();
  end
endmodule : test_boot_and_security_control
`default_nettype wire
